// ==== ivpm_defines.svh ====
// Constants for the interrupt vector and priority mapping block.
`ifndef IVPM_DEFINES_SVH
`define IVPM_DEFINES_SVH

// ****************************************************************
// Fixed levels and vectors
// ****************************************************************
`define IVPM_LVL_NMI        5'h10
`define IVPM_LVL_BREAK      5'h0F
`define IVPM_VEC_NMI        7'h0B
`define IVPM_VEC_BREAK      7'h0C
`define IVPM_VEC_DEBUG      7'h0D
`define IVPM_VEC_PIN_BASE   7'h40

// ****************************************************************
// Source slots, in default order from highest to lowest
// ****************************************************************
`define IVPM_NUM_SRC        12
`define IVPM_SLOT_NMI       0
`define IVPM_SLOT_PIN0      3
`define IVPM_SLOT_DMA0      7
`define IVPM_SLOT_DMA1      8
`define IVPM_SLOT_WDT       9
`define IVPM_SLOT_CMP_MATCH 10
`define IVPM_SLOT_ETH       11

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define IVPM_VEC_HI_MSB     14
`define IVPM_VEC_HI_LSB     8
`define IVPM_VEC_LO_MSB     6
`define IVPM_VEC_LO_LSB     0
`define IVPM_ETH_SRC_W      19
`define IVPM_MAC_SRC_W      3
`define IVPM_MAC_SUMMARY    18

`endif

// ==== ivpm_pkg.sv ====
// Types shared by the interrupt vector and priority mapping block.
package ivpm_pkg;

    // Acceptance sequence states, one-hot.
    typedef enum logic [2:0]
    {
        IVPM_IDLE    = 3'h1,
        IVPM_FETCH   = 3'h2,
        IVPM_PRESENT = 3'h4
    } ivpm_state_type;

endpackage : ivpm_pkg

// ==== ivpm_core.sv ====
// Interrupt vector and priority mapping: arbitration and vector delivery.
`timescale 1ns/1ps
`include "ivpm_defines.svh"

// Operation
// - An external agent may supply the vector in a fetch cycle instead of the fixed pin vector.
// - Each peripheral request takes its vector from a 7-bit field, bits 14-8 or 6-0.
// - A mode bit chooses 15 level-encoded requests or four independent pins.
// - The Ethernet request is the OR of the 19 status sources whose permit bit is set.
// - The three MAC status bits copy into one summary status bit, up to 22 sources.
// - In four-pin mode pins 0 to 3 use vectors 64 to 67 and nibbles of register C from 15-12.
// - The refresh compare match shares the watchdog level and uses its bits 6-0.
module ivpm_core
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        external_pin_mode_select,
    input  wire logic        ext_vector_fetch_enable,
    input  wire logic [3:0]  ext_req_pin_n,
    input  wire logic        nmi_pin,
    input  wire logic        break_req,
    input  wire logic        debug_req,
    input  wire logic        dma0_req,
    input  wire logic        dma1_req,
    input  wire logic        watchdog_req,
    input  wire logic        compare_match_request,
    input  wire logic [3:0]  dma_priority,
    input  wire logic [3:0]  watchdog_priority,
    input  wire logic [3:0]  ether_priority,
    input  wire logic [15:0] priority_level_register_c,
    input  wire logic [15:0] dma0_vector_register,
    input  wire logic [15:0] dma1_vector_register,
    input  wire logic [15:0] watchdog_vector_register,
    input  wire logic [15:0] ether_vector_register,
    input  wire logic [31:0] vector_base_register,
    input  wire logic [18:0] ether_status_event,
    input  wire logic [18:0] ether_status_clear,
    input  wire logic [18:0] ether_dma_permit_register,
    input  wire logic [2:0]  mac_status_register,
    input  wire logic [2:0]  mac_permit,
    input  wire logic [3:0]  interrupt_mask_level,
    input  wire logic        ext_fetch_ack,
    input  wire logic [6:0]  ext_fetch_vector,
    input  wire logic        core_ack,
    output logic [18:0]      ether_dma_status_register,
    output logic             ethernet_dma_request,
    output logic             ext_fetch_req,
    output logic             irq_valid,
    output logic [4:0]       irq_level,
    output logic [6:0]       irq_vector,
    output logic [31:0]      irq_table_addr
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic       nmi_prev_reg;
    logic       nmi_pend_reg;
    logic       nmi_pend_next;

    // Two flops on every pin before any logic looks at it.
    // They reset to each pin's idle level, so no false edge follows reset.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pin_meta_reg <= 5'h0F;
            pin_sync_reg <= 5'h0F;
            nmi_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= {nmi_pin, ext_req_pin_n};
            pin_sync_reg <= pin_meta_reg;
            nmi_prev_reg <= pin_sync_reg[4];
        end
    end

    // ****************************************************************
    // Ethernet DMA status and composite request
    // ****************************************************************
    logic [18:0] eth_status_reg;
    logic [18:0] eth_status_next;
    logic [18:0] mac_copy;
    logic        mac_summary_set;

    // Any permitted MAC status bit sets the summary bit.
    assign mac_summary_set = |(mac_status_register & mac_permit);
    assign mac_copy = mac_summary_set ?
        (19'h0_0001 << `IVPM_MAC_SUMMARY) : 19'h0_0000;
    // New events win over a clear in the same cycle.
    assign eth_status_next = (eth_status_reg & ~ether_status_clear)
                           | ether_status_event | mac_copy;
    assign ether_dma_status_register = eth_status_reg;
    // Composite request: OR of the permitted status sources.
    assign ethernet_dma_request =
        |(eth_status_reg & ether_dma_permit_register);

    // Sticky status bits.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            eth_status_reg <= 19'h0_0000;
        else
            eth_status_reg <= eth_status_next;
    end

    // ****************************************************************
    // Source table
    // ****************************************************************
    logic [`IVPM_NUM_SRC-1:0] src_req;
    logic [`IVPM_NUM_SRC-1:0] src_ext;
    logic [4:0]               src_lvl [`IVPM_NUM_SRC];
    logic [6:0]               src_vec [`IVPM_NUM_SRC];
    logic [3:0]               irl_level;
    logic                     four_pin;

    assign four_pin  = external_pin_mode_select;
    assign irl_level = ~pin_sync_reg[3:0];

    // Fixed sources: NMI at 16, break and debug at 15.
    assign src_req[0] = nmi_pend_reg;
    assign src_lvl[0] = `IVPM_LVL_NMI;
    assign src_vec[0] = `IVPM_VEC_NMI;
    assign src_req[1] = break_req;
    assign src_lvl[1] = `IVPM_LVL_BREAK;
    assign src_vec[1] = `IVPM_VEC_BREAK;
    assign src_req[2] = debug_req;
    assign src_lvl[2] = `IVPM_LVL_BREAK;
    assign src_vec[2] = `IVPM_VEC_DEBUG;
    assign src_ext[2:0] = 3'h0;

    // External pin slots; the mode bit decides their meaning.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pin
            localparam int SLOT = `IVPM_SLOT_PIN0 + gi;
            logic [6:0] irl_vec;
            logic       pin_req;
            assign irl_vec = `IVPM_VEC_PIN_BASE + {4'h0, irl_level[3:1]};
            assign pin_req = four_pin ? ~pin_sync_reg[gi]
                           : ((gi == 0) && (irl_level != 4'h0));
            assign src_req[SLOT] = pin_req;
            assign src_ext[SLOT] = 1'b1;
            assign src_lvl[SLOT] = four_pin ?
                {1'b0, priority_level_register_c[15-4*gi -: 4]}
                : {1'b0, irl_level};
            assign src_vec[SLOT] = four_pin ?
                (`IVPM_VEC_PIN_BASE + 7'(gi)) : irl_vec;
        end
    endgenerate

    // On-chip peripherals with software-written vector fields.
    assign src_req[7]  = dma0_req;
    assign src_lvl[7]  = {1'b0, dma_priority};
    assign src_vec[7]  = dma0_vector_register[6:0];
    assign src_req[8]  = dma1_req;
    assign src_lvl[8]  = {1'b0, dma_priority};
    assign src_vec[8]  = dma1_vector_register[6:0];
    assign src_req[9]  = watchdog_req;
    assign src_lvl[9]  = {1'b0, watchdog_priority};
    assign src_vec[9]  = watchdog_vector_register[14:8];
    assign src_req[10] = compare_match_request;
    assign src_lvl[10] = {1'b0, watchdog_priority};
    assign src_vec[10] = watchdog_vector_register[6:0];
    assign src_req[11] = ethernet_dma_request;
    assign src_lvl[11] = {1'b0, ether_priority};
    assign src_vec[11] = ether_vector_register[14:8];
    assign src_ext[11:7] = 5'h00;

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic       win_found;
    logic [3:0] win_idx;
    logic [4:0] win_lvl;
    logic       grant;

    // Strict compare keeps the earlier slot on equal levels.
    always_comb
    begin
        win_found = 1'b0;
        win_idx   = 4'h0;
        win_lvl   = 5'h00;
        for (int i = 0; i < `IVPM_NUM_SRC; i++)
        begin
            if (src_req[i] && (!win_found || src_lvl[i] > win_lvl))
            begin
                win_found = 1'b1;
                win_idx   = 4'(i);
                win_lvl   = src_lvl[i];
            end
        end
    end

    assign grant = win_found && (win_lvl > {1'b0, interrupt_mask_level});

    // ****************************************************************
    // Acceptance sequence
    // ****************************************************************
    ivpm_pkg::ivpm_state_type state_reg;
    ivpm_pkg::ivpm_state_type state_next;
    logic       idle;
    logic       to_fetch;
    logic       load_vec;
    logic [6:0] load_value;
    logic [4:0] level_reg;
    logic [6:0] vector_reg;
    logic [31:0] addr_reg;

    assign idle     = (state_reg == ivpm_pkg::IVPM_IDLE);
    assign to_fetch = idle && grant && src_ext[win_idx]
                    && ext_vector_fetch_enable;
    assign load_vec = (idle && grant && !to_fetch)
                    || (ext_fetch_req && ext_fetch_ack);
    // The agent's vector is 7 bits wide, so it stays in 0 to 127.
    assign load_value = ext_fetch_req ? ext_fetch_vector
                      : src_vec[win_idx];
    assign ext_fetch_req = (state_reg == ivpm_pkg::IVPM_FETCH);
    assign irq_valid     = (state_reg == ivpm_pkg::IVPM_PRESENT);
    assign irq_level      = level_reg;
    assign irq_vector     = vector_reg;
    assign irq_table_addr = addr_reg;
    // A new NMI edge wins over the clear on acceptance.
    assign nmi_pend_next = (pin_sync_reg[4] && !nmi_prev_reg)
        || (nmi_pend_reg
            && !(idle && grant && win_idx == 4'(`IVPM_SLOT_NMI)));

    // Next state selection.
    always_comb
    begin
        case (state_reg)
            ivpm_pkg::IVPM_IDLE:
                state_next = to_fetch ? ivpm_pkg::IVPM_FETCH
                           : grant ? ivpm_pkg::IVPM_PRESENT
                           : ivpm_pkg::IVPM_IDLE;
            ivpm_pkg::IVPM_FETCH:
                state_next = ext_fetch_ack ? ivpm_pkg::IVPM_PRESENT
                           : ivpm_pkg::IVPM_FETCH;
            ivpm_pkg::IVPM_PRESENT:
                state_next = core_ack ? ivpm_pkg::IVPM_IDLE
                           : ivpm_pkg::IVPM_PRESENT;
            default:
                state_next = ivpm_pkg::IVPM_IDLE;
        endcase
    end

    // State, captured level, vector and table address.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg    <= ivpm_pkg::IVPM_IDLE;
            nmi_pend_reg <= 1'b0;
            level_reg    <= 5'h00;
            vector_reg   <= 7'h00;
            addr_reg     <= 32'h0000_0000;
        end
        else
        begin
            state_reg    <= state_next;
            nmi_pend_reg <= nmi_pend_next;
            if (idle && grant)
                level_reg <= win_lvl;
            if (load_vec)
            begin
                vector_reg <= load_value;
                addr_reg   <= vector_base_register
                            + {23'h00_0000, load_value, 2'h0};
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_TABLE_ADDR: assert property (
        $rose(irq_valid) |-> irq_table_addr ==
        $past(vector_base_register) + {23'h00_0000, irq_vector, 2'h0})
        else $error("Table address is not base plus four times vector.");
    AST_NMI_LEVEL: assert property (
        idle && grant && win_idx == 4'h0 |=> irq_valid
        && irq_level == 5'h10 && irq_vector == 7'h0B)
        else $error("NMI not delivered at level 16 with vector 11.");
    AST_PIN_VECTOR: assert property (
        idle && grant && four_pin && !ext_vector_fetch_enable
        && win_idx >= 4'h3 && win_idx <= 4'h6
        |=> irq_vector == 7'h40 + 7'($past(win_idx) - 4'h3))
        else $error("Pin request vector is not 64 to 67.");
    AST_FETCH_START: assert property (
        to_fetch |=> ext_fetch_req && !irq_valid)
        else $error("External vector fetch did not start.");
    AST_FETCH_VECTOR: assert property (
        ext_fetch_req && ext_fetch_ack |=> irq_valid
        && irq_vector == $past(ext_fetch_vector))
        else $error("Fetched vector was not delivered.");
    AST_ETH_OR: assert property (
        |($past(ether_status_event) & ether_dma_permit_register)
        && $stable(ether_dma_permit_register) |-> ethernet_dma_request)
        else $error("Permitted status event did not raise the request.");
    AST_MAC_SUMMARY: assert property (
        |(mac_status_register & mac_permit)
        |=> ether_dma_status_register[`IVPM_MAC_SUMMARY])
        else $error("MAC status was not copied to the summary bit.");
    AST_CMI_VECTOR: assert property (
        idle && grant && win_idx == 4'hA |=> irq_valid
        && irq_level == {1'b0, $past(watchdog_priority)}
        && irq_vector == $past(watchdog_vector_register[6:0]))
        else $error("Compare match not mapped through watchdog fields.");
    AST_DMA_VECTOR: assert property (
        idle && grant && win_idx == 4'h7
        |=> irq_vector == $past(dma0_vector_register[6:0]))
        else $error("DMA vector not taken from its field.");
    AST_LEVEL_MODE: assert property (
        !four_pin |-> src_req[6:4] == 3'h0)
        else $error("Extra pin sources active in level-encoded mode.");
    AST_IRL_LEVEL: assert property (
        !four_pin && idle && grant && win_idx == 4'h3
        |=> irq_level == {1'b0, ~$past(pin_sync_reg[3:0])})
        else $error("Level-encoded pins gave the wrong level.");
    AST_TIE_ORDER: assert property (
        idle && grant && src_req[8] && win_lvl == src_lvl[8]
        |-> win_idx <= 4'h8)
        else $error("Equal level request skipped default order.");

    CVR_FETCH: cover property (ext_fetch_req ##[1:4] irq_valid);
    CVR_NMI: cover property (idle && grant && win_idx == 4'h0);
    CVR_ETH: cover property (idle && grant && win_idx == 4'hB);
    CVR_IRL: cover property (!four_pin && idle && grant
                             && win_idx == 4'h3);

endmodule : ivpm_core

// ==== ivpm_far_model.sv ====
// Behavioural model of the core exception logic and the vector agent.
`timescale 1ns/1ps

module ivpm_far_model
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       irq_valid,
    input  wire logic       ext_fetch_req,
    input  wire logic [3:0] ack_wait,
    input  wire logic [6:0] fetch_value,
    output logic            core_ack,
    output logic            ext_fetch_ack,
    output logic [6:0]      ext_fetch_vector,
    output int unsigned     ack_count
);
    logic [3:0] core_wait_reg;
    logic [3:0] fetch_wait_reg;

    // ****************************************************************
    // Core side
    // ****************************************************************
    // The core takes a presented interrupt after ack_wait waiting cycles.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            core_ack      <= 1'b0;
            core_wait_reg <= 4'h0;
            ack_count     <= 0;
        end
        else
        begin
            core_ack <= 1'b0;
            if (core_ack)
                ack_count <= ack_count + 1;
            else if (irq_valid && core_wait_reg >= ack_wait)
            begin
                core_ack      <= 1'b1;
                core_wait_reg <= 4'h0;
            end
            else if (irq_valid)
                core_wait_reg <= core_wait_reg + 4'h1;
        end
    end

    // ****************************************************************
    // Vector agent side
    // ****************************************************************
    // The agent answers a fetch with a 7-bit vector; between answers the
    // vector lines toggle so that a stale value is never mistaken.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ext_fetch_ack    <= 1'b0;
            ext_fetch_vector <= 7'h00;
            fetch_wait_reg   <= 4'h0;
        end
        else if (ext_fetch_req && !ext_fetch_ack && fetch_wait_reg >= ack_wait)
        begin
            ext_fetch_ack    <= 1'b1;
            ext_fetch_vector <= fetch_value;
            fetch_wait_reg   <= 4'h0;
        end
        else
        begin
            ext_fetch_ack    <= 1'b0;
            ext_fetch_vector <= ~ext_fetch_vector;
            fetch_wait_reg   <= ext_fetch_req ? fetch_wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : ivpm_far_model

// ==== testbench.sv ====
// Self-checking testbench for the interrupt vector and priority mapping.
`timescale 1ns/1ps

module testbench;
    logic        core_clk, srst, external_pin_mode_select, nmi_pin;
    logic        ext_vector_fetch_enable, break_req, debug_req;
    logic        dma0_req, dma1_req, watchdog_req, compare_match_request;
    logic        ext_fetch_ack, core_ack, ethernet_dma_request;
    logic        ext_fetch_req, irq_valid;
    logic [3:0]  ext_req_pin_n, dma_priority, watchdog_priority;
    logic [3:0]  ether_priority, interrupt_mask_level, ack_wait;
    logic [15:0] priority_level_register_c, dma0_vector_register;
    logic [15:0] dma1_vector_register, watchdog_vector_register;
    logic [15:0] ether_vector_register;
    logic [31:0] vector_base_register, irq_table_addr;
    logic [18:0] ether_status_event, ether_status_clear;
    logic [18:0] ether_dma_permit_register, ether_dma_status_register;
    logic [2:0]  mac_status_register, mac_permit;
    logic [6:0]  ext_fetch_vector, fetch_value, irq_vector;
    logic [4:0]  irq_level;
    int unsigned ack_count;
    int          num_errors, samples_checked, cycle_count;

    // Design and far-side model.
    ivpm_core dut_u (.core_clk, .srst, .external_pin_mode_select,
        .ext_vector_fetch_enable, .ext_req_pin_n, .nmi_pin, .break_req,
        .debug_req, .dma0_req, .dma1_req, .watchdog_req,
        .compare_match_request, .dma_priority, .watchdog_priority,
        .ether_priority, .priority_level_register_c, .dma0_vector_register,
        .dma1_vector_register, .watchdog_vector_register,
        .ether_vector_register, .vector_base_register, .ether_status_event,
        .ether_status_clear, .ether_dma_permit_register,
        .mac_status_register, .mac_permit, .interrupt_mask_level,
        .ext_fetch_ack, .ext_fetch_vector, .core_ack,
        .ether_dma_status_register, .ethernet_dma_request, .ext_fetch_req,
        .irq_valid, .irq_level, .irq_vector, .irq_table_addr);
    ivpm_far_model far_u (.core_clk, .srst, .irq_valid, .ext_fetch_req,
        .ack_wait, .fetch_value, .core_ack, .ext_fetch_ack,
        .ext_fetch_vector, .ack_count);

    // ****************************************************************
    // Clock, timeout and shared tasks
    // ****************************************************************
    // The 50 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // A hung run is cut short and counted as a mismatch.
    always @(posedge core_clk)
    begin
        cycle_count++;
        if (cycle_count == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end

    // Steps past n rising edges, landing just after the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // Compares one value and reports a difference.
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Waits for a presented interrupt and checks level, vector and address.
    task automatic take(input logic [4:0] lvl, input logic [6:0] vec);
        for (int n = 0; n < 40 && irq_valid !== 1'b1; n++) tick(1);
        check("irq_valid", 1, irq_valid);
        check("irq_level", lvl, irq_level);
        check("irq_vector", vec, irq_vector);
        check("irq_table_addr", vector_base_register + {vec, 2'b00},
              irq_table_addr);
    endtask : take

    // Waits until the core has taken the interrupt, then one idle cycle.
    task automatic done();
        int unsigned start;
        start = ack_count;
        for (int n = 0; n < 40 && ack_count == start; n++) tick(1);
        check("core_taken", 1, ack_count != start);
        tick(1);
    endtask : done

    // One-cycle pulses on the status set and clear inputs.
    task automatic pulse(input logic [18:0] ev, input logic [18:0] clr);
        ether_status_event = ev;
        ether_status_clear = clr;
        tick(1);
        ether_status_event = 19'h0_0000;
        ether_status_clear = 19'h0_0000;
        tick(1);
    endtask : pulse

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {srst, nmi_pin, break_req, debug_req, dma0_req, dma1_req} = 6'h20;
        {watchdog_req, compare_match_request} = 2'h0;
        {external_pin_mode_select, ext_vector_fetch_enable} = 2'h0;
        ext_req_pin_n = 4'hF;
        {dma_priority, watchdog_priority, ether_priority} = 12'h559;
        {interrupt_mask_level, ack_wait, fetch_value} = 15'h0000;
        priority_level_register_c = 16'h9ABC;
        dma0_vector_register = 16'h5AA5;
        dma1_vector_register = 16'h0011;
        watchdog_vector_register = 16'h3A45;
        ether_vector_register = 16'h2200;
        vector_base_register = 32'h0000_1000;
        {ether_status_event, ether_status_clear} = 38'h0_0000_0000;
        ether_dma_permit_register = 19'h4_0008;
        {mac_status_register, mac_permit} = 6'h00;
        {num_errors, samples_checked} = 0;
        tick(6);
        check("reset_outputs", 0, {irq_valid, ext_fetch_req, irq_vector,
              ethernet_dma_request, ether_dma_status_register});
        srst = 1'b0;
        tick(3);
        // Peripheral vector field and table address, prompt core.
        dma0_req = 1'b1;
        take(5'h05, 7'h25);
        dma0_req = 1'b0;
        done();
        // Refusal at the mask, then equal levels in default order.
        ack_wait = 4'h3;
        {dma_priority, watchdog_priority, interrupt_mask_level} = 12'h777;
        {dma1_req, watchdog_req, compare_match_request} = 3'h7;
        tick(8);
        check("irq_valid_masked", 0, irq_valid);
        interrupt_mask_level = 4'h0;
        take(5'h07, 7'h11);
        dma1_req = 1'b0;
        done();
        take(5'h07, 7'h3A);
        watchdog_req = 1'b0;
        done();
        take(5'h07, 7'h45);
        compare_match_request = 1'b0;
        done();
        // Sticky status, permit gating and the MAC summary bit.
        interrupt_mask_level = 4'hF;
        pulse(19'h0_0020, 19'h0_0000);
        check("ether_status", 19'h0_0020, ether_dma_status_register);
        check("ether_req_off", 0, ethernet_dma_request);
        pulse(19'h0_0008, 19'h0_0000);
        check("ether_req_on", 1, ethernet_dma_request);
        pulse(19'h0_0000, 19'h7_FFFF);
        check("ether_req_clear", 0, ethernet_dma_request);
        {mac_status_register, mac_permit} = 6'h12;
        tick(1);
        mac_status_register = 3'h0;
        check("mac_summary", 19'h4_0000, ether_dma_status_register);
        check("ether_req_mac", 1, ethernet_dma_request);
        interrupt_mask_level = 4'h0;
        take(5'h09, 7'h22);
        pulse(19'h0_0000, 19'h7_FFFF);
        done();
        // Four independent pins, fixed vectors and nibble levels.
        external_pin_mode_select = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ext_req_pin_n = ~(4'h1 << i);
            take({1'b0, priority_level_register_c[15 - 4 * i -: 4]},
                 7'(7'h40 + i));
            ext_req_pin_n = 4'hF;
            done();
        end
        // Level-encoded pins: level nine.
        external_pin_mode_select = 1'b0;
        ext_req_pin_n = 4'h6;
        take(5'h09, 7'h44);
        ext_req_pin_n = 4'hF;
        done();
        // External vector fetch at both ends of the vector range.
        {external_pin_mode_select, ext_vector_fetch_enable} = 2'h3;
        for (int k = 0; k < 2; k++)
        begin
            fetch_value = k ? 7'h00 : 7'h7F;
            ext_req_pin_n = 4'hD;
            for (int n = 0; n < 20 && ext_fetch_req !== 1'b1; n++) tick(1);
            check("fetch_req", 2'h2, {ext_fetch_req, irq_valid});
            take(5'h0A, fetch_value);
            ext_req_pin_n = 4'hF;
            done();
        end
        // Fixed levels and vectors of the non-maskable and break requests.
        ext_vector_fetch_enable = 1'b0;
        nmi_pin = 1'b1;
        take(5'h10, 7'h0B);
        nmi_pin = 1'b0;
        done();
        {break_req, debug_req} = 2'h3;
        take(5'h0F, 7'h0C);
        break_req = 1'b0;
        done();
        take(5'h0F, 7'h0D);
        debug_req = 1'b0;
        done();
        complete_run();
    end
endmodule : testbench
